// file: rtl/adc_host_end.sv
`timescale 1ns/1ns
`include "adc_readout_defines.svh"
module adc_host_end #(
    parameter int CHAIN_DEVICES = 1,
    parameter int SCK_HALF = `SCK_HALF_CYCLES,
    parameter int CNV_HIGH = `CNV_HIGH_CYCLES,
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_chain_mode,
    input wire logic i_convert,
    input wire logic i_sleep,
    input wire logic i_wake,
    output adc_readout_pkg::result_type o_word,
    output logic o_word_valid,
    input wire logic i_word_ready,
    output logic o_idle,
    output logic o_asleep,
    adc_readout_if.host_mp link
);
    import adc_readout_pkg::*;

    localparam logic [4:0] LAST_BIT = 5'(`RESULT_BITS - 1);

    if (CHAIN_DEVICES < 1 || CHAIN_DEVICES > 255 || SCK_HALF < 4 || SCK_HALF > 65535 || CNV_HIGH < 1
        || CNV_HIGH > 65535 || WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_param
        $error("adc_host_end parameter out of range");
    end

    // Busy and serial line synchronisers
    logic [1:0] meta_q;
    logic [1:0] sync_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= {link.serial_line, link.busy};
            sync_q <= meta_q;
        end
    end

    host_state_type state_q;
    logic [15:0] cnt_q;
    logic [4:0] bit_q;
    logic [7:0] word_q;
    logic sleeping_q;
    logic pulses_q;
    logic seen_busy_q;
    result_type shift_q;
    logic cnv_q;
    logic sck_q;
    logic rdl_q;
    logic fifo_ready;
    logic last_tick;

    assign last_tick = (cnt_q == 16'h0001);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 5'h00;
            word_q <= 8'h00;
            sleeping_q <= 1'b0;
            pulses_q <= 1'b0;
            seen_busy_q <= 1'b0;
            shift_q <= '0;
            cnv_q <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (i_sleep || i_convert) begin
                        sleeping_q <= i_sleep;
                        pulses_q <= 1'b0;
                        cnv_q <= 1'b1;
                        cnt_q <= CNV_HIGH[15:0];
                        state_q <= ST_CNV;
                    end
                end
                ST_CNV: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (last_tick) begin
                        cnv_q <= 1'b0;
                        seen_busy_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (sync_q[0]) begin
                        seen_busy_q <= 1'b1;
                    end else if (seen_busy_q) begin
                        if (sleeping_q && pulses_q) begin
                            state_q <= ST_ASLEEP;
                        end else if (sleeping_q) begin
                            pulses_q <= 1'b1;
                            cnv_q <= 1'b1;
                            cnt_q <= CNV_HIGH[15:0];
                            state_q <= ST_CNV;
                        end else begin
                            bit_q <= 5'h00;
                            word_q <= 8'h00;
                            // Extra cycles let the newly enabled line pass the sampler's synchroniser
                            cnt_q <= SCK_HALF[15:0] + 16'h0004;
                            state_q <= ST_SHIFT_LO;
                        end
                    end
                end
                ST_SHIFT_LO: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (last_tick) begin
                        shift_q <= {shift_q[`RESULT_BITS-2:0], sync_q[1]};
                        cnt_q <= SCK_HALF[15:0];
                        if (bit_q == LAST_BIT) begin
                            bit_q <= 5'h00;
                            state_q <= ST_PUSH;
                        end else begin
                            bit_q <= bit_q + 5'h01;
                            sck_q <= 1'b1;
                            state_q <= ST_SHIFT_HI;
                        end
                    end
                end
                ST_PUSH: begin
                    if (fifo_ready) begin
                        if (word_q == 8'(CHAIN_DEVICES - 1)) begin
                            state_q <= ST_IDLE;
                        end else begin
                            word_q <= word_q + 8'h01;
                            sck_q <= 1'b1;
                            state_q <= ST_SHIFT_HI;
                        end
                    end
                end
                ST_SHIFT_HI: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (last_tick) begin
                        sck_q <= 1'b0;
                        cnt_q <= SCK_HALF[15:0];
                        state_q <= ST_SHIFT_LO;
                    end
                end
                ST_ASLEEP: begin
                    if (i_wake) begin
                        sck_q <= 1'b1;
                        cnt_q <= SCK_HALF[15:0];
                        state_q <= ST_WAKE_PULSE;
                    end
                end
                ST_WAKE_PULSE: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (last_tick) begin
                        sck_q <= 1'b0;
                        cnt_q <= WAKE_CYCLES[15:0];
                        state_q <= ST_WAKE_WAIT;
                    end
                end
                ST_WAKE_WAIT: begin
                    cnt_q <= cnt_q - 16'h0001;
                    if (last_tick) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Read enable idles high in normal mode; low while this device is read, and held low throughout chain mode
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdl_q <= 1'b1;
        end else begin
            rdl_q <= !i_chain_mode && !(state_q == ST_SHIFT_LO || state_q == ST_SHIFT_HI || state_q == ST_PUSH);
        end
    end

    sample_fifo #(
        .WIDTH(`RESULT_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_data(shift_q),
        .i_in_valid(state_q == ST_PUSH),
        .o_in_ready(fifo_ready),
        .o_out_data(o_word),
        .o_out_valid(o_word_valid),
        .i_out_ready(i_word_ready)
    );

    assign link.conversion_start = cnv_q;
    assign link.shift_clock = sck_q;
    assign link.read_enable_or_serial_in = rdl_q;
    assign o_idle = (state_q == ST_IDLE);
    assign o_asleep = (state_q == ST_ASLEEP);
endmodule : adc_host_end

// file: rtl/adc_readout_defines.svh
`ifndef ADC_READOUT_DEFINES_SVH
`define ADC_READOUT_DEFINES_SVH

// Result word
`define RESULT_BITS 18

// Core clock
`define CLK_PERIOD_NS 100

// Longest conversion time, rounded down to whole cycles
`define CONV_TIME_NS 3000
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)

// Wake-up delay after leaving sleep, rounded up to whole cycles
`define WAKE_DELAY_US 1000
`define WAKE_CYCLES ((`WAKE_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Host shift clock half period and conversion-start pulse width
`define SCK_HALF_CYCLES 4
`define CNV_HIGH_CYCLES 2

// Result buffer depth
`define FIFO_DEPTH 8

`endif

// file: rtl/adc_readout_pkg.sv
`include "adc_readout_defines.svh"
package adc_readout_pkg;
    typedef logic [`RESULT_BITS-1:0] result_type;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CNV,
        ST_WAIT,
        ST_SHIFT_LO,
        ST_SHIFT_HI,
        ST_PUSH,
        ST_ASLEEP,
        ST_WAKE_PULSE,
        ST_WAKE_WAIT
    } host_state_type;
endpackage : adc_readout_pkg

// file: rtl/adc_readout_if.sv
`timescale 1ns/1ns
interface adc_readout_if;
    logic conversion_start;
    logic shift_clock;
    logic read_enable_or_serial_in;
    logic busy;
    logic serial_out;
    logic serial_out_oe_b;
    logic serial_line;

    // Released line idles high
    assign serial_line = serial_out_oe_b ? 1'b1 : serial_out;

    modport device_mp (
        input conversion_start,
        input shift_clock,
        input read_enable_or_serial_in,
        output busy,
        output serial_out,
        output serial_out_oe_b
    );

    modport host_mp (
        output conversion_start,
        output shift_clock,
        output read_enable_or_serial_in,
        input busy,
        input serial_line
    );
endinterface : adc_readout_if

// file: rtl/sample_fifo.sv
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic o_out_valid,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("sample_fifo needs a power-of-two depth of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign o_in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign o_out_valid = (wr_q != rd_q);
    assign o_out_data = mem[rd_q[AW-1:0]];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : sample_fifo

// file: rtl/adc_device_end.sv
`timescale 1ns/1ns
`include "adc_readout_defines.svh"
// Notes on behaviour
// - Shift only on clock edges while output enabled
// - Output changes on shift clock rising edge
// - Top bit holds until first rising edge
// - Host reads after conversion, fast shift clock
// - Normal mode: read enable low drives output
// - Top bit presented when busy falls
// - Host enables one shared device at once
// - Enabling output shows top bit at once
// - Chain mode: output always on, serial input
// - Chain input captured; appears after 18 edges
// - Host pulses start twice without clock edge
// - Sleep entered when last conversion ends
// - Shift clock rising edge wakes from sleep
// - Host waits wake-up delay before converting
// - Start edge begins conversion; no restart while busy
// - Host keeps start edges clear of conversions
// - Result still shifts out during nap
module adc_device_end #(
    parameter int CONV_CYCLES = `CONV_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_chain_mode,
    input wire adc_readout_pkg::result_type i_sample_data,
    output adc_readout_pkg::result_type o_last_result,
    output logic o_sample_taken,
    output logic o_core_powered,
    output logic o_napping,
    output logic o_asleep,
    output logic [4:0] o_bits_shifted,
    adc_readout_if.device_mp link
);
    import adc_readout_pkg::*;

    localparam int TOP = `RESULT_BITS - 1;

    if (CONV_CYCLES < 2 || CONV_CYCLES > 65535) begin : g_bad_param
        $error("adc_device_end conversion count out of range");
    end

    // Pin synchronisers: cnv, sck, serial in, chain select
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [3:0] prev_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            prev_q <= 4'h0;
        end else begin
            meta_q <= {i_chain_mode, link.read_enable_or_serial_in, link.shift_clock, link.conversion_start};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    logic cnv_rise;
    logic sck_rise;
    logic serial_in;
    logic chain;
    logic enabled;

    assign cnv_rise = sync_q[0] && !prev_q[0];
    assign sck_rise = sync_q[1] && !prev_q[1];
    assign serial_in = sync_q[2];
    assign chain = sync_q[3];
    assign enabled = chain || !serial_in;

    // Conversion timer
    logic busy_q;
    logic asleep_q;
    logic [15:0] conv_cnt_q;
    logic conv_start;
    logic conv_done;

    assign conv_start = cnv_rise && !busy_q && !asleep_q;
    assign conv_done = busy_q && (conv_cnt_q == 16'h0001);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_q <= 1'b0;
            conv_cnt_q <= 16'h0000;
        end else if (conv_start) begin
            busy_q <= 1'b1;
            conv_cnt_q <= CONV_CYCLES[15:0];
        end else if (busy_q) begin
            conv_cnt_q <= conv_cnt_q - 16'h0001;
            if (conv_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Double start pulse detection
    logic pending_q;
    logic sleep_req_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pending_q <= 1'b0;
        end else if (cnv_rise && !asleep_q) begin
            pending_q <= !pending_q || sck_rise;
        end else if (sck_rise) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sleep_req_q <= 1'b0;
        end else if (cnv_rise && !asleep_q && pending_q && !sck_rise) begin
            sleep_req_q <= 1'b1;
        end else if (conv_done) begin
            sleep_req_q <= 1'b0;
        end
    end

    // Sleep state
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            asleep_q <= 1'b0;
        end else if (conv_done && sleep_req_q) begin
            asleep_q <= 1'b1;
        end else if (asleep_q && sck_rise) begin
            asleep_q <= 1'b0;
        end
    end

    // Result shift register
    logic [TOP:0] shift_q;
    logic shift_now;

    assign shift_now = sck_rise && enabled && !asleep_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_q <= '0;
        end else if (conv_done) begin
            shift_q <= i_sample_data;
        end else if (shift_now) begin
            shift_q <= {shift_q[TOP-1:0], chain ? serial_in : 1'b0};
        end
    end

    // Bits shifted since the last result
    logic [4:0] bits_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bits_q <= 5'h00;
        end else if (conv_done) begin
            bits_q <= 5'h00;
        end else if (shift_now && bits_q != 5'h1f) begin
            bits_q <= bits_q + 5'h01;
        end
    end

    // Captured result and status
    logic sample_taken_q;
    result_type last_q;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sample_taken_q <= 1'b0;
            last_q <= '0;
        end else begin
            sample_taken_q <= conv_done;
            if (conv_done) begin
                last_q <= i_sample_data;
            end
        end
    end

    assign link.busy = busy_q;
    assign link.serial_out = shift_q[TOP];
    assign link.serial_out_oe_b = !enabled;
    assign o_last_result = last_q;
    assign o_sample_taken = sample_taken_q;
    assign o_core_powered = busy_q;
    assign o_napping = !busy_q && !asleep_q;
    assign o_asleep = asleep_q;
    assign o_bits_shifted = bits_q;
endmodule : adc_device_end

// file: sim/adc_readout_sva.sv
`timescale 1ns/1ns
module adc_readout_sva #(
    parameter int CONV_CYCLES = 30
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_chain_mode,
    input wire logic conversion_start,
    input wire logic shift_clock,
    input wire logic read_enable_or_serial_in,
    input wire logic busy,
    input wire logic serial_out,
    input wire logic serial_out_oe_b
);
    logic sck_prev_q;
    logic busy_prev_q;
    logic [15:0] busy_len_q;
    logic [3:0] since_sck_q;
    logic [4:0] sck_cnt_q;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    // Previous levels
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_prev_q <= 1'b0;
            busy_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= shift_clock;
            busy_prev_q <= busy;
        end
    end
    // Length of busy
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_len_q <= '0;
        end else if (busy) begin
            busy_len_q <= busy_len_q + 16'h1;
        end else begin
            busy_len_q <= '0;
        end
    end
    // Cycles since a shift clock rise
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            since_sck_q <= 4'hf;
        end else if (shift_clock && !sck_prev_q) begin
            since_sck_q <= 4'h0;
        end else if (since_sck_q != 4'hf) begin
            since_sck_q <= since_sck_q + 4'h1;
        end
    end
    // Shift clock rises per result
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_cnt_q <= '0;
        end else if (busy_prev_q && !busy) begin
            sck_cnt_q <= '0;
        end else if (shift_clock && !sck_prev_q) begin
            sck_cnt_q <= sck_cnt_q + 5'h1;
        end
    end
    chk_busy_starts: assert property ($rose(conversion_start) && !busy |-> ##[1:5] busy)
        else $error("busy did not follow start");
    chk_busy_length: assert property ($fell(busy) |-> busy_len_q == 16'(CONV_CYCLES))
        else $error("busy length wrong");
    chk_no_restart: assert property ($rose(conversion_start) |-> !busy)
        else $error("start edge while busy");
    chk_out_moves: assert property ($changed(serial_out) |-> $fell(busy) || since_sck_q < 4'h6)
        else $error("serial out moved without cause");
    chk_oe_release: assert property (!i_chain_mode && !$past(i_chain_mode, 4) && $rose(read_enable_or_serial_in)
        |-> ##[1:4] serial_out_oe_b)
        else $error("output not released");
    chk_oe_drive: assert property (!i_chain_mode && !$past(i_chain_mode, 4) && $fell(read_enable_or_serial_in)
        |-> ##[1:4] !serial_out_oe_b)
        else $error("output not driven");
    chk_chain_drives: assert property (i_chain_mode && $past(i_chain_mode, 4) |-> !serial_out_oe_b)
        else $error("chain output not driven");
    chk_read_after: assert property (busy |-> !$rose(shift_clock))
        else $error("shift clock during conversion");
    chk_rdl_idle: assert property (!i_chain_mode && busy |-> read_enable_or_serial_in)
        else $error("read enable low during conversion");
    chk_read_length: assert property ($rose(busy) |-> sck_cnt_q inside {5'd0, 5'd1, 5'd17})
        else $error("shift count per result wrong");
    cov_conv_done: cover property ($fell(busy));
    cov_read: cover property (!i_chain_mode && $fell(read_enable_or_serial_in));
    cov_chain: cover property (i_chain_mode && $rose(shift_clock));
endmodule : adc_readout_sva

// file: sim/tb.sv
`timescale 1ns/1ns
`include "adc_readout_defines.svh"
module tb;
    import adc_readout_pkg::*;
    localparam int CONV = `CONV_CYCLES;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic chain_mode = 1'b0;
    logic convert = 1'b0;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    logic word_ready = 1'b0;
    logic drain_en = 1'b0;
    result_type sample_data = '0;
    result_type word;
    result_type last_result;
    logic word_valid, host_idle, host_asleep, napping, dev_asleep;
    logic taken, powered;
    logic busy_d = 1'b0;
    logic [4:0] bits_shifted;
    int fails = 0;
    int n_checks = 0;
    integer seed = 32'h7141;
    result_type exp_q[$];
    adc_readout_if link_if ();
    adc_device_end #(.CONV_CYCLES(CONV)) u_adc_device_end (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_chain_mode(chain_mode), .i_sample_data(sample_data), .o_last_result(last_result),
        .o_sample_taken(taken), .o_core_powered(powered), .o_napping(napping), .o_asleep(dev_asleep),
        .o_bits_shifted(bits_shifted), .link(link_if));
    adc_host_end #(.WAKE_CYCLES(20)) u_adc_host_end (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_chain_mode(chain_mode), .i_convert(convert), .i_sleep(sleep_req), .i_wake(wake_req),
        .o_word(word), .o_word_valid(word_valid), .i_word_ready(word_ready), .o_idle(host_idle),
        .o_asleep(host_asleep), .link(link_if));
    adc_readout_sva #(.CONV_CYCLES(CONV)) u_adc_readout_sva (.i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_chain_mode(chain_mode), .conversion_start(link_if.conversion_start),
        .shift_clock(link_if.shift_clock), .read_enable_or_serial_in(link_if.read_enable_or_serial_in),
        .busy(link_if.busy), .serial_out(link_if.serial_out), .serial_out_oe_b(link_if.serial_out_oe_b));
    always #50 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        word_ready <= drain_en && (($random(seed) & 3) != 0);
        busy_d <= link_if.busy;
    end
    // Result taken exactly when busy falls
    always @(negedge i_clock) begin
        if (i_rst_b === 1'b1 && (taken === 1'b1 || (busy_d === 1'b1 && link_if.busy === 1'b0))) begin
            check("sample_taken", result_type'(busy_d && !link_if.busy), result_type'(taken));
        end
    end
    task automatic test_done();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input result_type exp, input result_type got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check
    // 0 host idle, 1 host asleep, 2 all words read
    task automatic wait_for(input int which, input int lim);
        int n;
        n = 0;
        while (n < lim && !((which == 0 && host_idle === 1'b1) || (which == 1 && host_asleep === 1'b1)
               || (which == 2 && exp_q.size() == 0))) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("BAD wait %0d exp done got timeout", which);
            test_done();
        end
    endtask : wait_for
    task automatic pulse(input int which);
        @(posedge i_clock);
        convert <= (which == 0);
        sleep_req <= (which == 1);
        wake_req <= (which == 2);
        @(posedge i_clock);
        convert <= 1'b0;
        sleep_req <= 1'b0;
        wake_req <= 1'b0;
    endtask : pulse
    task automatic run_conv(input bit stall);
        result_type v;
        v = result_type'($random(seed));
        @(posedge i_clock);
        sample_data <= v;
        exp_q.push_back(v);
        pulse(0);
        if (!stall) begin
            @(negedge i_clock);
            wait_for(0, 2000);
            check("last_result", v, last_result);
            check("bits_shifted", result_type'(5'd17), result_type'(bits_shifted));
            check("napping", result_type'(1'b1), result_type'(napping));
            check("core_powered", result_type'(1'b0), result_type'(powered));
        end
    endtask : run_conv
    // Model queue against every word read out
    always @(negedge i_clock) begin
        if (word_valid === 1'b1 && word_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("BAD word exp none got %h", word);
            end else begin
                check("word", exp_q.pop_front(), word);
            end
        end
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        drain_en <= 1'b1;
        repeat (3) run_conv(0);
        wait_for(2, 200);
        drain_en <= 1'b0;
        repeat (8) run_conv(0);
        run_conv(1);
        repeat (400) @(posedge i_clock);
        @(negedge i_clock);
        check("host_idle", result_type'(1'b0), result_type'(host_idle));
        check("word_valid", result_type'(1'b1), result_type'(word_valid));
        @(posedge i_clock);
        drain_en <= 1'b1;
        wait_for(0, 2000);
        wait_for(2, 2000);
        pulse(1);
        wait_for(1, 3000);
        check("dev_asleep", result_type'(1'b1), result_type'(dev_asleep));
        check("busy", result_type'(1'b0), result_type'(link_if.busy));
        pulse(2);
        wait_for(0, 3000);
        check("dev_awake", result_type'(1'b0), result_type'(dev_asleep));
        run_conv(0);
        @(posedge i_clock);
        chain_mode <= 1'b1;
        repeat (6) @(negedge i_clock);
        check("chain_oe_b", result_type'(1'b0), result_type'(link_if.serial_out_oe_b));
        repeat (2) run_conv(0);
        @(posedge i_clock);
        chain_mode <= 1'b0;
        repeat (6) @(negedge i_clock);
        check("idle_oe_b", result_type'(1'b1), result_type'(link_if.serial_out_oe_b));
        wait_for(2, 2000);
        test_done();
    end
    initial begin
        repeat (30000) @(posedge i_clock);
        fails++;
        $display("BAD watchdog exp done got timeout");
        test_done();
    end
endmodule : tb
